//--- common/bldq_pkg.sv
// Types shared by the bulk list and done queue pointer bank.
// Assumes the register offsets come from bldq_regs.svh.
package bldq_pkg;

  // Register access from the controller's register decoder
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } bldq_reg_req_type;

  // A pointer event with its address
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
  } bldq_ptr_evt_type;

  // Bulk walk state, one-hot
  typedef enum logic [2:0] {
    BL_IDLE = 3'h1,
    BL_WALK = 3'h2,
    BL_END = 3'h4
  } bldq_walk_type;

endpackage

//--- common/bldq_regs.svh
// Offsets, field positions and reset values of the bulk and done pointers.
// Assumes byte offsets from the host controller's register base.
`ifndef BLDQ_REGS_SVH
`define BLDQ_REGS_SVH

`define BLDQ_OFS_BULK_HEAD 8'h28
`define BLDQ_OFS_BULK_CURRENT 8'h2C
`define BLDQ_OFS_DONE_HEAD 8'h30
`define BLDQ_PTR_LSB 4
`define BLDQ_PTR_MSB 31
`define BLDQ_PTR_RESET 28'h0000000
`define BLDQ_RSVD_READ 4'h0

`endif

//--- dv/bldq_pointers_tb.sv
// Self-checking bench for the bulk list and done queue pointer bank.
// Assumes the package and register header are compiled first.
`timescale 1ns/10ps
`default_nettype none
module bldq_pointers_tb
  import bldq_pkg::*;
;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  bldq_reg_req_type reg_req;
  logic [31:0] reg_rdata;
  logic reg_rvalid;
  logic bulk_list_enable = 1'b0;
  logic list_filled_flag = 1'b0;
  logic list_filled_clear;
  bldq_ptr_evt_type init_head = '0;
  logic frame_start = 1'b0;
  bldq_ptr_evt_type endpoint_done = '0;
  logic serve_valid;
  logic [31:0] serve_addr;
  bldq_ptr_evt_type transfer_done = '0;
  bldq_ptr_evt_type transfer_link;
  logic wb_req = 1'b0;
  bldq_ptr_evt_type wb_out;
  int fails = 0;
  int cmp_count = 0;
  int cycles = 0;

  bldq_pointers dut (.core_clk(core_clk), .reset_n(reset_n),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .bulk_list_enable(bulk_list_enable), .list_filled_flag(list_filled_flag),
    .list_filled_clear(list_filled_clear), .init_head(init_head),
    .frame_start(frame_start), .endpoint_done(endpoint_done),
    .serve_valid(serve_valid), .serve_addr(serve_addr),
    .transfer_done(transfer_done), .transfer_link(transfer_link),
    .wb_req(wb_req), .wb_out(wb_out));

  bldq_sw_model sw (.core_clk(core_clk), .bulk_list_enable(bulk_list_enable),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  // 40 MHz clock
  always #12.5 core_clk = ~core_clk;

  // Hang guard: the whole run needs well under a hundred cycles
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      fails++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("compares=%0d mismatches=%0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Inputs move one time unit after the rising edge
  task automatic step();
    @(posedge core_clk);
    #1;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    sw.rd(a, d);
    check(d, exp);
  endtask

  // Pulse one event input (two for k=5) for a single cycle; registered answers follow.
  // An idle edge comes first so no input is set where the last call cleared it.
  task automatic kick(input int k, input logic [31:0] a);
    step();
    case (k)
      0: endpoint_done = '{1'b1, a};
      1: frame_start = 1'b1;
      2: transfer_done = '{1'b1, a};
      3: init_head = '{1'b1, a};
      5:
      begin
        transfer_done = '{1'b1, a};
        wb_req = 1'b1;
      end
      default: wb_req = 1'b1;
    endcase
    step();
    endpoint_done = '0;
    transfer_done = '0;
    init_head = '0;
    frame_start = 1'b0;
    wb_req = 1'b0;
  endtask

  // Main sequence
  initial
  begin
    repeat (8) step();
    reset_n = 1'b1;
    step();
    rc(8'h28, 32'h0);
    rc(8'h2C, 32'h0);
    rc(8'h30, 32'h0);
    rc(8'h34, 32'h0);
    $display("test reset values done");
    sw.wr(8'h28, 32'h1234567F);
    rc(8'h28, 32'h12345670);
    kick(3, 32'h0000A000);
    rc(8'h28, 32'h0000A000);
    $display("test head pointer done");
    sw.wr(8'h2C, 32'h0000300F);
    rc(8'h2C, 32'h00003000);
    bulk_list_enable = 1'b1;
    step();
    check({31'h0, serve_valid}, 32'h1);
    check(serve_addr, 32'h00003000);
    kick(0, 32'h00003100);
    check(serve_addr, 32'h00003100);
    rc(8'h2C, 32'h00003100);
    kick(0, 32'h00000000);
    check({31'h0, serve_valid}, 32'h0);
    kick(1, 32'h0);
    check(serve_addr, 32'h0);
    check({31'h0, list_filled_clear}, 32'h0);
    list_filled_flag = 1'b1;
    kick(1, 32'h0);
    check(serve_addr, 32'h0000A000);
    check({31'h0, list_filled_clear}, 32'h1);
    list_filled_flag = 1'b0;
    kick(0, 32'h0000B000);
    kick(1, 32'h0);
    check(serve_addr, 32'h0000B000);
    $display("test bulk walk done");
    kick(2, 32'h00004000);
    check(transfer_link.addr, 32'h0);
    kick(2, 32'h00004100);
    check({31'h0, transfer_link.valid}, 32'h1);
    check(transfer_link.addr, 32'h00004000);
    rc(8'h30, 32'h00004100);
    kick(4, 32'h0);
    check({31'h0, wb_out.valid}, 32'h1);
    check(wb_out.addr, 32'h00004100);
    rc(8'h30, 32'h0);
    // Completion and write-back in one cycle: the completion is written back
    kick(5, 32'h00004200);
    check(transfer_link.addr, 32'h0);
    check(wb_out.addr, 32'h00004200);
    rc(8'h30, 32'h0);
    $display("test done queue done");
    print_verdict();
  end
endmodule
`default_nettype wire

//--- dv/bldq_sw_model.sv
// Driver software model: word reads and writes on the register access port.
// Assumes callers enter its tasks just after a rising core_clk edge.
`timescale 1ns/10ps
`default_nettype none
module bldq_sw_model
  import bldq_pkg::*;
(
  // Clock and status
  input wire logic core_clk,
  input wire logic bulk_list_enable,
  // Register access
  output var bldq_reg_req_type reg_req,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial reg_req = '0;

  // One-cycle write; data turned over afterwards so stale values never match.
  // Each access ends with an idle edge, so back-to-back calls never set a
  // strobe in the time step that cleared it.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    if (a == 8'h2C && bulk_list_enable)
      return;
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk);
    #1 reg_req.wr = 1'b0;
    reg_req.wdata = ~d;
    @(posedge core_clk);
    #1;
  endtask

  // Read answer is taken in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge core_clk);
    #1 reg_req.rd = 1'b0;
    d = reg_rvalid ? reg_rdata : 32'hFFFFFFFF;
    @(posedge core_clk);
    #1;
  endtask
endmodule
`default_nettype wire

//--- verilog/bldq_pointers.sv
// Bulk list head/current pointers and done queue head of the host controller.
// Assumes the list scheduler and memory engine of the core drive the events
// below, all synchronous to core_clk, each event a one-cycle pulse.
`timescale 1ns/10ps
`default_nettype none
`include "bldq_regs.svh"

module bldq_pointers
  import bldq_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Register access
  input wire bldq_reg_req_type reg_req,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  // Control and status bits held elsewhere in the controller
  input wire logic bulk_list_enable,
  input wire logic list_filled_flag,
  output logic list_filled_clear,
  // Initialisation from the shared communication area
  input wire bldq_ptr_evt_type init_head,
  // Bulk list walk
  input wire logic frame_start,
  input wire bldq_ptr_evt_type endpoint_done,
  output logic serve_valid,
  output logic [31:0] serve_addr,
  // Done queue
  input wire bldq_ptr_evt_type transfer_done,
  output bldq_ptr_evt_type transfer_link,
  input wire logic wb_req,
  output bldq_ptr_evt_type wb_out
);

  // Stored pointer fields, bits 31:4 only
  logic [27:0] bulk_head_addr;
  logic [27:0] bulk_current_addr;
  logic [27:0] done_queue_addr;
  logic [27:0] next_bulk_head_addr;
  logic [27:0] next_bulk_current_addr;
  logic [27:0] next_done_queue_addr;
  logic [31:0] next_reg_rdata;
  logic next_reg_rvalid;
  logic next_list_filled_clear;
  bldq_ptr_evt_type next_transfer_link;
  bldq_ptr_evt_type next_wb_out;
  bldq_walk_type walk_state;
  bldq_walk_type next_walk_state;
  logic list_end;
  logic [27:0] endpoint_next_field;

  // Address match, used by the write and read decoders
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // Pointer as seen on the bus, reserved nibble forced to zero
  function automatic logic [31:0] as_word(input logic [27:0] p);
    as_word = {p, `BLDQ_RSVD_READ};
  endfunction

  assign endpoint_next_field =
    endpoint_done.addr[`BLDQ_PTR_MSB:`BLDQ_PTR_LSB];

  // End of list: a served descriptor links to zero, or a frame opens on zero
  assign list_end = bulk_list_enable &&
    ((endpoint_done.valid && endpoint_next_field == 28'h0000000) ||
     (frame_start && bulk_current_addr == 28'h0000000));

  // Bulk head: software write, overridden by load at initialisation
  always_comb
  begin
    next_bulk_head_addr = bulk_head_addr;
    if (init_head.valid)
    begin
      next_bulk_head_addr =
        init_head.addr[`BLDQ_PTR_MSB:`BLDQ_PTR_LSB];
    end
    else if (reg_req.wr && hit(reg_req.addr, `BLDQ_OFS_BULK_HEAD))
    begin
      next_bulk_head_addr =
        reg_req.wdata[`BLDQ_PTR_MSB:`BLDQ_PTR_LSB];
    end
  end

  // Bulk current: hardware walk while enabled, software write otherwise
  always_comb
  begin
    next_bulk_current_addr = bulk_current_addr;
    next_list_filled_clear = 1'b0;
    if (list_end)
    begin
      if (list_filled_flag)
      begin
        next_bulk_current_addr = bulk_head_addr;
        next_list_filled_clear = 1'b1;
      end
      else if (endpoint_done.valid)
      begin
        next_bulk_current_addr = 28'h0000000;
      end
    end
    else if (bulk_list_enable && endpoint_done.valid)
    begin
      // Follow the link, so order is insertion order
      next_bulk_current_addr = endpoint_next_field;
    end
    else if (!bulk_list_enable && reg_req.wr &&
             hit(reg_req.addr, `BLDQ_OFS_BULK_CURRENT))
    begin
      // Writes while enabled are dropped so the walk is never torn
      next_bulk_current_addr =
        reg_req.wdata[`BLDQ_PTR_MSB:`BLDQ_PTR_LSB];
    end
  end

  // Done queue: completion links and replaces, write-back clears
  always_comb
  begin
    next_done_queue_addr = done_queue_addr;
    next_transfer_link = '0;
    next_wb_out = '0;
    if (transfer_done.valid)
    begin
      next_transfer_link.valid = 1'b1;
      next_transfer_link.addr = as_word(done_queue_addr);
      next_done_queue_addr =
        transfer_done.addr[`BLDQ_PTR_MSB:`BLDQ_PTR_LSB];
    end
    else if (reg_req.wr && hit(reg_req.addr, `BLDQ_OFS_DONE_HEAD))
    begin
      next_done_queue_addr =
        reg_req.wdata[`BLDQ_PTR_MSB:`BLDQ_PTR_LSB];
    end
    if (wb_req)
    begin
      // A completion in the same cycle is part of the written head
      next_wb_out.valid = 1'b1;
      next_wb_out.addr = as_word(next_done_queue_addr);
      next_done_queue_addr = 28'h0000000;
    end
  end

  // Read path, one cycle latency; unmapped offsets read zero
  always_comb
  begin
    next_reg_rvalid = reg_req.rd;
    next_reg_rdata = 32'h00000000;
    if (reg_req.rd && hit(reg_req.addr, `BLDQ_OFS_BULK_HEAD))
    begin
      next_reg_rdata = as_word(bulk_head_addr);
    end
    else if (reg_req.rd && hit(reg_req.addr, `BLDQ_OFS_BULK_CURRENT))
    begin
      next_reg_rdata = as_word(bulk_current_addr);
    end
    else if (reg_req.rd && hit(reg_req.addr, `BLDQ_OFS_DONE_HEAD))
    begin
      next_reg_rdata = as_word(done_queue_addr);
    end
  end

  // Walk state follows enable and the current pointer
  always_comb
  begin
    next_walk_state = walk_state;
    case (walk_state)
      BL_IDLE:
        if (bulk_list_enable)
        begin
          next_walk_state = (next_bulk_current_addr == 28'h0000000) ?
            BL_END : BL_WALK;
        end
      BL_WALK:
        if (!bulk_list_enable)
        begin
          next_walk_state = BL_IDLE;
        end
        else if (next_bulk_current_addr == 28'h0000000)
        begin
          next_walk_state = BL_END;
        end
      BL_END:
        if (!bulk_list_enable)
        begin
          next_walk_state = BL_IDLE;
        end
        else if (next_bulk_current_addr != 28'h0000000)
        begin
          next_walk_state = BL_WALK;
        end
      default:
        next_walk_state = BL_IDLE;
    endcase
  end

  // Register all state
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bulk_head_addr <= `BLDQ_PTR_RESET;
      bulk_current_addr <= `BLDQ_PTR_RESET;
      done_queue_addr <= `BLDQ_PTR_RESET;
      reg_rdata <= 32'h00000000;
      reg_rvalid <= 1'b0;
      list_filled_clear <= 1'b0;
      transfer_link <= '0;
      wb_out <= '0;
      walk_state <= BL_IDLE;
    end
    else
    begin
      bulk_head_addr <= next_bulk_head_addr;
      bulk_current_addr <= next_bulk_current_addr;
      done_queue_addr <= next_done_queue_addr;
      reg_rdata <= next_reg_rdata;
      reg_rvalid <= next_reg_rvalid;
      list_filled_clear <= next_list_filled_clear;
      transfer_link <= next_transfer_link;
      wb_out <= next_wb_out;
      walk_state <= next_walk_state;
    end
  end

  // The scheduler serves what the current pointer names, valid only while the walk is in BL_WALK
  assign serve_addr = as_word(bulk_current_addr);
  assign serve_valid = (walk_state == BL_WALK);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // Helper: plain advance, no list end in the same cycle
  logic adv;
  assign adv = bulk_list_enable && endpoint_done.valid && !list_end;

  // Register bus and head: reserved nibble, write landing, read-back and load at initialisation
  a_rsvd_zero: assert property (
    reg_rvalid |-> reg_rdata[3:0] == 4'h0)
    else $error("reserved bits not zero");
  a_head_wr: assert property (
    (reg_req.wr && !init_head.valid &&
    reg_req.addr == `BLDQ_OFS_BULK_HEAD) |=>
    bulk_head_addr == $past(reg_req.wdata[31:4]))
    else $error("bulk head write lost");
  a_head_read: assert property (
    (reg_req.rd && reg_req.addr == `BLDQ_OFS_BULK_HEAD) |=>
    reg_rdata == {$past(bulk_head_addr), 4'h0})
    else $error("bulk head read wrong");
  a_init_load: assert property (
    init_head.valid |=> bulk_head_addr == $past(init_head.addr[31:4]))
    else $error("head not loaded at init");

  // Bulk walk: advance, end of list and frame boundaries
  a_endpoint_advance: assert property (
    adv |=> serve_addr == {$past(endpoint_done.addr[31:4]), 4'h0})
    else $error("current pointer did not advance");
  a_end_reload: assert property (
    (list_end && list_filled_flag) |=> list_filled_clear &&
    serve_addr == {$past(bulk_head_addr), 4'h0})
    else $error("reload at list end failed");
  a_end_hold: assert property (
    (list_end && !list_filled_flag && !endpoint_done.valid) |=>
    !list_filled_clear && $stable(serve_addr))
    else $error("current moved with flag clear");
  // Only while enabled: a disabled list may legally take a software write
  a_frame_resume: assert property (
    (frame_start && bulk_list_enable && !endpoint_done.valid &&
    !list_end) |=> $stable(serve_addr))
    else $error("frame start disturbed current");
  a_locked_write: assert property (
    (bulk_list_enable && !endpoint_done.valid && !list_end) |=>
    $stable(bulk_current_addr))
    else $error("current changed while idle and enabled");

  // Done queue: link value, write-back value, clear and pulse widths
  a_transfer_link: assert property (
    transfer_done.valid |=> transfer_link.valid &&
    transfer_link.addr == {$past(done_queue_addr), 4'h0})
    else $error("done link wrong");
  a_link_pulse: assert property (
    !transfer_done.valid |=> !transfer_link.valid)
    else $error("done link without completion");
  a_wb_clear: assert property (
    wb_req |=> wb_out.valid && done_queue_addr == 28'h0000000)
    else $error("done head not cleared on write-back");
  a_wb_value: assert property (
    (wb_req && !transfer_done.valid && !reg_req.wr) |=>
    wb_out.addr == {$past(done_queue_addr), 4'h0})
    else $error("written-back done head wrong");
  a_wb_pulse: assert property (
    !wb_req |=> !wb_out.valid)
    else $error("write-back without request");

  // Main scenarios worth seeing at least once
  c_reload: cover property (list_end && list_filled_flag);
  c_walk_to_end: cover property (adv ##[1:20] list_end);
  c_transfer_then_wb: cover property (transfer_done.valid ##[1:10] wb_req);
  c_wb_same: cover property (transfer_done.valid && wb_req);

endmodule
`default_nettype wire
